// File: dv/tpc_cc_monitor.sv
// assertion checker for the timer pair common control ports
`timescale 1ns/1ps
module tpc_cc_monitor
  import tpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic demod_input,
  input wire logic demod_mode,
  input wire tpc_submode_t long_timer_submode,
  input wire logic short_timer_output,
  input wire logic long_timer_output,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic [7:0] wd;
  assign acc = psel && penable && pwrite && pready;
  // last written data, held so the checks can look at it after the bus moves on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd <= 8'h00;
    end else if (acc) begin
      wd <= pwdata[7:0];
    end
  end
  // ********************************
  // checks
  // ********************************
  mode_write_a: assert property (acc && paddr == 12'h008
    |=> ##[0:1] demod_mode == (wd != 8'h00)) else $error("mode does not follow write");
  demod_sub_a: assert property (demod_mode && $past(demod_mode)
    |-> long_timer_submode == TPC_SUB_NORMAL) else $error("submode live in demod");
  demod_out_a: assert property (demod_mode && $past(demod_mode)
    |-> !short_timer_output && !long_timer_output) else $error("outputs live in demod");
  ctrl_write_a: assert property (acc && paddr == 12'h004 && !demod_mode
    |=> ##[0:1] (long_timer_submode == wd[3:2] && short_timer_output == wd[1]))
    else $error("control write not applied");
  long_level_a: assert property (acc && paddr == 12'h004 && !demod_mode && !pwdata[3]
    |=> ##[0:1] long_timer_output == wd[0]) else $error("long start level wrong");
  force_low_a: assert property (!demod_mode && long_timer_submode == TPC_SUB_FORCE_LOW
    |-> !long_timer_output) else $error("long output not forced low");
  force_high_a: assert property (!demod_mode && long_timer_submode == TPC_SUB_FORCE_HIGH
    |-> long_timer_output) else $error("long output not forced high");
  irq_quiet_a: assert property ((!demod_mode && !psel) [*6] |=> !$rose(irq))
    else $error("edge event outside demod");
endmodule
bind tpc_common_control tpc_cc_monitor u_tpc_cc_monitor (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .demod_input, .demod_mode,
  .long_timer_submode, .short_timer_output, .long_timer_output, .irq);

// File: dv/tpc_testbench.sv
// self-checking bench for the timer pair common control block
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic demod_input = 1'b0, pready, pslverr, irq, ei = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic [33:0] q[$];
  int n_fail = 0, checks_done = 0, cyc = 0;
  integer seed = 32'h82b9_6f33;
  tpc_common_control u_tpc_common_control (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .demod_input, .demod_mode(),
    .long_timer_submode(), .short_timer_output(), .long_timer_output(), .irq);
  always #2.5 pclk = ~pclk;
  // ********************************
  // tasks
  // ********************************
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // one edge idles after release so psel is never driven twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back({a > 12'h018, ei, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic pulse(input int n);
    demod_input <= 1'b1;
    repeat (n) @(posedge pclk);
    demod_input <= 1'b0;
    repeat (20) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
      chk({pslverr, irq, prdata}, q.pop_front());
    end
    if (cyc == 6000) begin
      n_fail++;
      final_report();
    end
  end
  // ********************************
  // scenarios
  // ********************************
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h004, 32'h0000_0000);
    rd(12'h008, 32'h0000_0000);
    rd(12'h01C, 32'h0000_0000);
    for (int s = 0; s < 4; s++) begin
      r = $random(seed);
      wr(12'h004, {28'h000_0000, s[1:0], r[1:0]});
      rd(12'h004, {28'h000_0000, s[1:0], r[1:0]});
      rd(12'h018, {30'h0000_0000, r[1], (s == 3) | ((s < 2) & r[0])});
    end
    wr(12'h008, 32'h0000_0001);
    rd(12'h018, 32'h0000_0000);
    // short pulse is rejected, long one passes and sets both flags
    for (int f = 1; f < 3; f++) begin
      wr(12'h004, {28'h000_0000, f[1:0], 2'b00});
      pulse(4 * f - 2);
      rd(12'h004, {28'h000_0000, f[1:0], 2'b00});
      pulse(4 * f + 2);
      rd(12'h004, {28'h000_0000, f[1:0], 2'b11});
      wr(12'h004, {28'h000_0000, f[1:0], 2'b11});
      rd(12'h004, {28'h000_0000, f[1:0], 2'b00});
    end
    wr(12'h004, 32'h0000_0000);
    pulse(2);
    rd(12'h004, 32'h0000_0003);
    wr(12'h004, 32'h0000_0002);
    rd(12'h004, 32'h0000_0001);
    wr(12'h004, 32'h0000_0001);
    rd(12'h004, 32'h0000_0000);
    wr(12'h010, 32'h0000_0003);
    pulse(2);
    rd(12'h00C, 32'h0000_0003);
    ei = 1'b1;
    wr(12'h014, 32'h0000_0002);
    rd(12'h014, 32'h0000_0002);
    ei = 1'b0;
    wr(12'h014, 32'h0000_0000);
    rd(12'h00C, 32'h0000_0003);
    wr(12'h010, 32'h0000_0002);
    wr(12'h014, 32'h0000_0002);
    rd(12'h00C, 32'h0000_0001);
    final_report();
  end
endmodule

// File: rtl/tpc_common_control.sv
// timer pair common control register with apb slave and edge interrupts
`timescale 1ns/1ps
`include "tpc_defs.svh"
// Summary of operation
// - the pair is in transmit mode when the mode result is zero, else in demodulation mode.
// - in transmit mode bits 3:2 pick normal, ping-pong, force long output low or high.
// - in demodulation mode bits 3:2 pick no filter, 4-cycle, 8-cycle filter or reserved.
// - in transmit mode bit 1 is read/write and sets the short timer output start level.
// - in transmit mode bit 0 is read/write and sets the long timer output start level.
// - in demodulation mode bit 1 reads a sticky rising-edge flag, zero after reset.
// - in demodulation mode writing one to bit 1 clears the rising flag, zero does nothing.
// - in demodulation mode bit 0 reads a sticky falling-edge flag; writing zero does nothing.
module tpc_common_control
  import tpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic demod_input,
  output logic demod_mode,
  output tpc_submode_t long_timer_submode,
  output logic short_timer_output,
  output logic long_timer_output,
  output logic irq
);
  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    tpc_ctrl_t ctrl;
    logic mode;
    tpc_edges_t flags;
    tpc_edges_t status;
    tpc_edges_t enable;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic demod;
    tpc_submode_t sub;
    logic short_out;
    logic long_out;
    logic irq;
  } tpc_state_t;
  tpc_state_t st;
  tpc_state_t next_st;
  logic filtered;
  tpc_edges_t edges;
  logic wr;
  logic rd;
  tpc_edges_t clr;
  // ***************************************************************
  // input path
  // ***************************************************************
  // filter also synchronises the pin; edge logic never sees the raw input
  tpc_glitch_filter u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .raw_in(demod_input),
    .filter_sel(tpc_filter_t'(st.ctrl.submode)),
    .filtered(filtered)
  );
  tpc_edge_detect u_edges (
    .pclk(pclk),
    .presetn(presetn),
    .level_in(filtered),
    .edges(edges)
  );
  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    next_st = st;
    wr = psel & penable & pwrite & ~st.ready;
    rd = psel & penable & ~pwrite & ~st.ready;
    clr = '0;
    next_st.ready = psel & penable & ~st.ready;
    next_st.err = 1'b0;
    if (wr || rd) begin
      case (paddr)
        `TPC_ADDR_COMMON_CONTROL, `TPC_ADDR_MODE_CTRL, `TPC_ADDR_IRQ_STATUS,
        `TPC_ADDR_IRQ_CLEAR, `TPC_ADDR_IRQ_ENABLE, `TPC_ADDR_OUT_STATE: begin
          next_st.err = 1'b0;
        end
        default: begin
          next_st.err = `TPC_PSLVERR_UNMAPPED;
        end
      endcase
    end
    if (wr) begin
      case (paddr)
        `TPC_ADDR_COMMON_CONTROL: begin
          next_st.ctrl.submode = pwdata[`TPC_BIT_SUB_HI:`TPC_BIT_SUB_LO];
          if (!st.mode) begin
            next_st.ctrl.short_output_start_level = pwdata[`TPC_BIT_SHORT_LEVEL];
            next_st.ctrl.long_output_start_level = pwdata[`TPC_BIT_LONG_LEVEL];
          end else begin
            clr.rise = pwdata[`TPC_BIT_SHORT_LEVEL];
            clr.fall = pwdata[`TPC_BIT_LONG_LEVEL];
          end
        end
        `TPC_ADDR_MODE_CTRL: begin
          next_st.mode = |pwdata[7:0];
        end
        `TPC_ADDR_IRQ_CLEAR: begin
          next_st.status.rise = st.status.rise & ~pwdata[1];
          next_st.status.fall = st.status.fall & ~pwdata[0];
        end
        `TPC_ADDR_IRQ_ENABLE: begin
          next_st.enable.rise = pwdata[1];
          next_st.enable.fall = pwdata[0];
        end
        default: begin
        end
      endcase
    end
    // sticky flags: a detected edge wins over a clear in the same cycle
    if (st.mode) begin
      next_st.flags.rise = edges.rise | (st.flags.rise & ~clr.rise);
      next_st.flags.fall = edges.fall | (st.flags.fall & ~clr.fall);
      next_st.status.rise = edges.rise | next_st.status.rise;
      next_st.status.fall = edges.fall | next_st.status.fall;
    end
    if (rd) begin
      next_st.rdata = 32'h0000_0000;
      case (paddr)
        `TPC_ADDR_COMMON_CONTROL: begin
          next_st.rdata[`TPC_BIT_SUB_HI:`TPC_BIT_SUB_LO] = st.ctrl.submode;
          if (!st.mode) begin
            next_st.rdata[`TPC_BIT_SHORT_LEVEL] = st.ctrl.short_output_start_level;
            next_st.rdata[`TPC_BIT_LONG_LEVEL] = st.ctrl.long_output_start_level;
          end else begin
            next_st.rdata[`TPC_BIT_SHORT_LEVEL] = st.flags.rise;
            next_st.rdata[`TPC_BIT_LONG_LEVEL] = st.flags.fall;
          end
        end
        `TPC_ADDR_MODE_CTRL: next_st.rdata[0] = st.mode;
        `TPC_ADDR_IRQ_STATUS: next_st.rdata[1:0] = st.status;
        `TPC_ADDR_IRQ_ENABLE: next_st.rdata[1:0] = st.enable;
        `TPC_ADDR_OUT_STATE: next_st.rdata[1:0] = {st.short_out, st.long_out};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    // outputs: short at its start level; long at its start level in normal and ping-pong, forced otherwise; both low in demod
    next_st.demod = st.mode;
    next_st.sub = tpc_submode_t'(st.ctrl.submode);
    next_st.short_out = st.ctrl.short_output_start_level;
    case (tpc_submode_t'(st.ctrl.submode))
      TPC_SUB_FORCE_LOW: next_st.long_out = 1'b0;
      TPC_SUB_FORCE_HIGH: next_st.long_out = 1'b1;
      default: next_st.long_out = st.ctrl.long_output_start_level;
    endcase
    if (st.mode) begin
      next_st.sub = TPC_SUB_NORMAL;
      next_st.short_out = 1'b0;
      next_st.long_out = 1'b0;
    end
    next_st.irq = |(next_st.status & next_st.enable);
  end
  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.err;
  assign demod_mode = st.demod;
  assign long_timer_submode = st.sub;
  assign short_timer_output = st.short_out;
  assign long_timer_output = st.long_out;
  assign irq = st.irq;
endmodule

// File: rtl/tpc_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH
`define TPC_IDX_COMMON_CONTROL 8'h01
`define TPC_ADDR_COMMON_CONTROL 12'h004
`define TPC_ADDR_MODE_CTRL 12'h008
`define TPC_ADDR_IRQ_STATUS 12'h00C
`define TPC_ADDR_IRQ_CLEAR 12'h010
`define TPC_ADDR_IRQ_ENABLE 12'h014
`define TPC_ADDR_OUT_STATE 12'h018
`define TPC_BIT_LONG_LEVEL 0
`define TPC_BIT_SHORT_LEVEL 1
`define TPC_BIT_SUB_LO 2
`define TPC_BIT_SUB_HI 3
`define TPC_CTRL_RESET 4'h0
`define TPC_FILT4_CYCLES 4
`define TPC_FILT8_CYCLES 8
`define TPC_PSLVERR_UNMAPPED 1'b1
`endif

// File: rtl/tpc_edge_detect.sv
// edge detector on the filtered demodulator input
`timescale 1ns/1ps
module tpc_edge_detect
  import tpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level_in,
  output tpc_edges_t edges
);
  typedef struct packed {
    logic prev;
  } tpc_ed_state_t;
  tpc_ed_state_t st;
  tpc_ed_state_t next_st;
  always_comb begin
    next_st.prev = level_in;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign edges.rise = level_in & ~st.prev;
  assign edges.fall = ~level_in & st.prev;
endmodule

// File: rtl/tpc_glitch_filter.sv
// input synchroniser and pulse-width glitch filter
`timescale 1ns/1ps
`include "tpc_defs.svh"
module tpc_glitch_filter
  import tpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic raw_in,
  input wire tpc_filter_t filter_sel,
  output logic filtered
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [3:0] cnt;
    logic level;
  } tpc_gf_state_t;
  tpc_gf_state_t st;
  tpc_gf_state_t next_st;
  logic [3:0] need;
  always_comb begin
    next_st = st;
    need = 4'h0;
    next_st.sync1 = raw_in;
    next_st.sync2 = st.sync1;
    case (filter_sel)
      TPC_FILT_4: need = 4'(`TPC_FILT4_CYCLES);
      TPC_FILT_8: need = 4'(`TPC_FILT8_CYCLES);
      default: need = 4'h0;
    endcase
    // a new level must stand need cycles before it is passed on
    if (st.sync2 == st.level) begin
      next_st.cnt = 4'h0;
    end else if (need == 4'h0 || st.cnt + 4'h1 >= need) begin
      next_st.level = st.sync2;
      next_st.cnt = 4'h0;
    end else begin
      next_st.cnt = st.cnt + 4'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign filtered = st.level;
endmodule

// File: rtl/tpc_pkg.sv
// types shared by the timer pair common control block
package tpc_pkg;
  typedef enum logic [1:0] {
    TPC_SUB_NORMAL,
    TPC_SUB_PINGPONG,
    TPC_SUB_FORCE_LOW,
    TPC_SUB_FORCE_HIGH
  } tpc_submode_t;
  typedef enum logic [1:0] {
    TPC_FILT_NONE,
    TPC_FILT_4,
    TPC_FILT_8,
    TPC_FILT_RSVD
  } tpc_filter_t;
  typedef struct packed {
    logic [1:0] submode;
    logic short_output_start_level;
    logic long_output_start_level;
  } tpc_ctrl_t;
  typedef struct packed {
    logic rise;
    logic fall;
  } tpc_edges_t;
endpackage
